// file: rtl/pweq_port_ctrl_regs.vh
// register map, field positions, reset values and codes of the per-port
// drop and egress queue control bank; definitions only
`ifndef PWEQ_PORT_CTRL_REGS_VH
`define PWEQ_PORT_CTRL_REGS_VH

// ==========================================
// byte addresses inside the port's 4 kB window
`define PWEQ_ADDR_POLICE_CTRL     12'h80c
`define PWEQ_ADDR_PM_THRESHOLDS   12'h830
`define PWEQ_ADDR_PM_MULT_AVG     12'h834
`define PWEQ_ADDR_Q_THRESHOLDS    12'h840
`define PWEQ_ADDR_Q_MULT_AVG      12'h844
`define PWEQ_ADDR_Q_MON_CTRL      12'h848
`define PWEQ_ADDR_Q_SELECT        12'h900
`define PWEQ_ADDR_VID_SWAP        12'h904
`define PWEQ_ADDR_SCHED_SHAPER    12'h914

// ==========================================
// field positions
`define PWEQ_HI_MSB               26
`define PWEQ_HI_LSB               16
`define PWEQ_LO_MSB               10
`define PWEQ_LO_LSB               0
`define PWEQ_BIT_RAND_DROP_EN     31
`define PWEQ_BIT_FLUSH            30
`define PWEQ_BIT_ALL_COLOR_OFF    29
`define PWEQ_BIT_UPPER_COLOR_OFF  28
`define PWEQ_BIT_RED_OFF          27
`define PWEQ_BIT_DROP_ALL         26
`define PWEQ_CNT_MSB              23
`define PWEQ_IDX_BYTE3_MSB        25
`define PWEQ_IDX_BYTE3_LSB        24
`define PWEQ_SCHED_MSB            7
`define PWEQ_SCHED_LSB            6
`define PWEQ_SHAPER_MSB           5
`define PWEQ_SHAPER_LSB           4
`define PWEQ_WEIGHT_MSB           14
`define PWEQ_WEIGHT_LSB           8
`define PWEQ_STRB_BYTE3_ONLY      4'h8

// ==========================================
// reset values
`define PWEQ_RST_PM_MAX           11'h400
`define PWEQ_RST_PM_MIN           11'h080
`define PWEQ_RST_PM_MULT          11'h020
`define PWEQ_RST_Q_MAX            11'h080
`define PWEQ_RST_Q_MIN            11'h009
`define PWEQ_RST_Q_MULT           11'h010
`define PWEQ_RST_SCHED            2'h2
`define PWEQ_RST_SHAPER           2'h0
`define PWEQ_RST_WEIGHT           7'h01

// ==========================================
// codes
`define PWEQ_SCHED_STRICT         2'h0
`define PWEQ_SCHED_ROTATION       2'h2
`define PWEQ_COLOR_GREEN          2'h0
`define PWEQ_COLOR_YELLOW         2'h1
`define PWEQ_COLOR_RED            2'h2
`define PWEQ_NUMQ_ONE             2'h0
`define PWEQ_NUMQ_TWO             2'h1
`define PWEQ_MASK_ONE             4'h1
`define PWEQ_MASK_TWO             4'h3
`define PWEQ_MASK_FOUR            4'hf
`define PWEQ_PROB_SHIFT           7

`endif

// file: rtl/pweq_port_ctrl.v
// per-port random early drop, monitor counter and egress queue control
// assumes an apb master on the same clock and a switch datapath on the
// same clock that feeds averages, event pulses and drop checks
//
// Added by the designer: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "pweq_port_ctrl_regs.vh"

module pweq_port_ctrl
#(
  parameter NQ = 4
)
(
  input  wire                 clock,
  input  wire                 rst_n,
  input  wire                 psel,
  input  wire                 penable,
  input  wire                 pwrite,
  input  wire [11:0]          paddr,
  input  wire [31:0]          pwdata,
  input  wire [3:0]           pstrb,
  output wire [31:0]          prdata,
  output wire                 pready,
  output wire                 pslverr,
  input  wire [10:0]          pmAvgSize,
  input  wire [11*NQ-1:0]     qAvgSize,
  input  wire [NQ-1:0]        pktEvent,
  input  wire                 chkValid,
  input  wire [1:0]           chkQueue,
  input  wire [1:0]           chkColor,
  input  wire [10:0]          chkRand,
  output wire                 dropValid,
  output wire                 dropPkt,
  input  wire [1:0]           txNumQueues,
  input  wire [NQ-1:0]        qNotEmpty,
  input  wire                 txPick,
  output wire                 grantValid,
  output wire [1:0]           grantQueue,
  output wire [2*NQ-1:0]      shaperMode,
  output wire                 vidSwapEn
);

  // ==========================================
  // state
  reg  [31:0] prdata_r;
  reg         pready_r;
  reg         pslverr_r;
  reg         policeEn_r;
  reg  [10:0] pmMax_r;
  reg  [10:0] pmMin_r;
  reg  [10:0] pmMult_r;
  reg  [10:0] qMax_r    [0:NQ-1];
  reg  [10:0] qMin_r    [0:NQ-1];
  reg  [10:0] qMult_r   [0:NQ-1];
  reg  [1:0]  sched_r   [0:NQ-1];
  reg  [1:0]  shaper_r  [0:NQ-1];
  reg  [6:0]  weight_r  [0:NQ-1];
  reg  [23:0] evCnt_r   [0:NQ-1];
  reg         randDropEn_r;
  reg         flushBit_r;
  reg         allColorOff_r;
  reg         upperColorOff_r;
  reg         redOff_r;
  reg         dropAll_r;
  reg  [1:0]  qIdx_r;
  reg         vidSwap_r;
  reg         dropValid_r;
  reg         dropPkt_r;
  reg         grantValid_r;
  reg  [1:0]  grantQueue_r;
  reg  [1:0]  curQ_r;
  reg  [6:0]  sent_r;
  integer     i;

  // ==========================================
  // byte-lane merge so partial writes keep the untouched lanes
  function [31:0] mergeLanes;
    input [31:0] old;
    input [31:0] wd;
    input [3:0]  st;
    integer k;
    begin
      for (k = 0; k < 4; k = k + 1)
        mergeLanes[8*k +: 8] = st[k] ? wd[8*k +: 8] : old[8*k +: 8];
    end
  endfunction

  // ==========================================
  // apb decode
  wire        accPhase = psel & penable;
  wire        wrEn     = accPhase & pready_r & pwrite;
  wire [11:0] wAddr    = {paddr[11:2], 2'h0};
  wire [10:0] qAvgSel  = qAvgSize[11*qIdx_r +: 11];

  wire [31:0] pmThrWord = {5'h0, pmMax_r, 5'h0, pmMin_r};
  wire [31:0] pmMulWord = {5'h0, pmMult_r, 5'h0, pmAvgSize};
  wire [31:0] qThrWord  = {5'h0, qMax_r[qIdx_r], 5'h0, qMin_r[qIdx_r]};
  wire [31:0] qMulWord  = {5'h0, qMult_r[qIdx_r], 5'h0, qAvgSel};
  wire [31:0] monWord   = {randDropEn_r, flushBit_r, allColorOff_r,
                           upperColorOff_r, redOff_r, dropAll_r, 2'h0,
                           evCnt_r[qIdx_r]};
  wire [31:0] selWord   = {6'h0, qIdx_r, 22'h0, qIdx_r};
  wire [31:0] vidWord   = {31'h0, vidSwap_r};
  wire [31:0] schWord   = {17'h0, weight_r[qIdx_r], sched_r[qIdx_r],
                           shaper_r[qIdx_r], 4'h0};

  reg  [31:0] rdWord;
  reg         hit;
  always @*
  begin
    rdWord = 32'h0;
    hit    = 1'b1;
    if (wAddr == `PWEQ_ADDR_POLICE_CTRL)
      rdWord = {31'h0, policeEn_r};
    else if (wAddr == `PWEQ_ADDR_PM_THRESHOLDS)
      rdWord = pmThrWord;
    else if (wAddr == `PWEQ_ADDR_PM_MULT_AVG)
      rdWord = pmMulWord;
    else if (wAddr == `PWEQ_ADDR_Q_THRESHOLDS)
      rdWord = qThrWord;
    else if (wAddr == `PWEQ_ADDR_Q_MULT_AVG)
      rdWord = qMulWord;
    else if (wAddr == `PWEQ_ADDR_Q_MON_CTRL)
      rdWord = monWord;
    else if (wAddr == `PWEQ_ADDR_Q_SELECT)
      rdWord = selWord;
    else if (wAddr == `PWEQ_ADDR_VID_SWAP)
      rdWord = vidWord;
    else if (wAddr == `PWEQ_ADDR_SCHED_SHAPER)
      rdWord = schWord;
    else
      hit = 1'b0;
  end

  wire [31:0] pmThrNxt = mergeLanes(pmThrWord, pwdata, pstrb);
  wire [31:0] pmMulNxt = mergeLanes(pmMulWord, pwdata, pstrb);
  wire [31:0] qThrNxt  = mergeLanes(qThrWord, pwdata, pstrb);
  wire [31:0] qMulNxt  = mergeLanes(qMulWord, pwdata, pstrb);
  wire [31:0] monNxt   = mergeLanes(monWord, pwdata, pstrb);
  wire [31:0] schNxt   = mergeLanes(schWord, pwdata, pstrb);

  wire wrMon    = wrEn & (wAddr == `PWEQ_ADDR_Q_MON_CTRL);
  // only a 0 to 1 step of the stored bit flushes
  wire flushHit = wrMon & monNxt[`PWEQ_BIT_FLUSH] & ~flushBit_r;

  // ==========================================
  // apb answer: one wait state so read data leaves a flip-flop
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r  <= accPhase & ~pready_r;
      pslverr_r <= accPhase & ~pready_r & ~hit;
      if (accPhase & ~pready_r & ~pwrite)
        prdata_r <= rdWord;
      else
        prdata_r <= 32'h0;
    end
  end

  // ==========================================
  // register writes
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      policeEn_r      <= 1'b0;
      pmMax_r         <= `PWEQ_RST_PM_MAX;
      pmMin_r         <= `PWEQ_RST_PM_MIN;
      pmMult_r        <= `PWEQ_RST_PM_MULT;
      randDropEn_r    <= 1'b0;
      flushBit_r      <= 1'b0;
      allColorOff_r   <= 1'b0;
      upperColorOff_r <= 1'b0;
      redOff_r        <= 1'b0;
      dropAll_r       <= 1'b0;
      qIdx_r          <= 2'h0;
      vidSwap_r       <= 1'b0;
      for (i = 0; i < NQ; i = i + 1)
      begin
        qMax_r[i]   <= `PWEQ_RST_Q_MAX;
        qMin_r[i]   <= `PWEQ_RST_Q_MIN;
        qMult_r[i]  <= `PWEQ_RST_Q_MULT;
        sched_r[i]  <= `PWEQ_RST_SCHED;
        shaper_r[i] <= `PWEQ_RST_SHAPER;
        weight_r[i] <= `PWEQ_RST_WEIGHT;
      end
    end
    else if (wrEn)
    begin
      if (wAddr == `PWEQ_ADDR_POLICE_CTRL && pstrb[0])
        policeEn_r <= pwdata[0];
      else if (wAddr == `PWEQ_ADDR_PM_THRESHOLDS)
      begin
        pmMax_r <= pmThrNxt[`PWEQ_HI_MSB:`PWEQ_HI_LSB];
        pmMin_r <= pmThrNxt[`PWEQ_LO_MSB:`PWEQ_LO_LSB];
      end
      else if (wAddr == `PWEQ_ADDR_PM_MULT_AVG)
        pmMult_r <= pmMulNxt[`PWEQ_HI_MSB:`PWEQ_HI_LSB];
      else if (wAddr == `PWEQ_ADDR_Q_THRESHOLDS)
      begin
        qMax_r[qIdx_r] <= qThrNxt[`PWEQ_HI_MSB:`PWEQ_HI_LSB];
        qMin_r[qIdx_r] <= qThrNxt[`PWEQ_LO_MSB:`PWEQ_LO_LSB];
      end
      else if (wAddr == `PWEQ_ADDR_Q_MULT_AVG)
        qMult_r[qIdx_r] <= qMulNxt[`PWEQ_HI_MSB:`PWEQ_HI_LSB];
      else if (wAddr == `PWEQ_ADDR_Q_MON_CTRL)
      begin
        randDropEn_r    <= monNxt[`PWEQ_BIT_RAND_DROP_EN];
        flushBit_r      <= monNxt[`PWEQ_BIT_FLUSH];
        allColorOff_r   <= monNxt[`PWEQ_BIT_ALL_COLOR_OFF];
        upperColorOff_r <= monNxt[`PWEQ_BIT_UPPER_COLOR_OFF];
        redOff_r        <= monNxt[`PWEQ_BIT_RED_OFF];
        dropAll_r       <= monNxt[`PWEQ_BIT_DROP_ALL];
      end
      else if (wAddr == `PWEQ_ADDR_Q_SELECT)
      begin
        if (pstrb == `PWEQ_STRB_BYTE3_ONLY)
          qIdx_r <= pwdata[`PWEQ_IDX_BYTE3_MSB:`PWEQ_IDX_BYTE3_LSB];
        else if (pstrb[0])
          qIdx_r <= pwdata[1:0];
      end
      else if (wAddr == `PWEQ_ADDR_VID_SWAP && pstrb[0])
        vidSwap_r <= pwdata[0];
      else if (wAddr == `PWEQ_ADDR_SCHED_SHAPER)
      begin
        sched_r[qIdx_r]  <= schNxt[`PWEQ_SCHED_MSB:`PWEQ_SCHED_LSB];
        shaper_r[qIdx_r] <= schNxt[`PWEQ_SHAPER_MSB:`PWEQ_SHAPER_LSB];
        weight_r[qIdx_r] <= schNxt[`PWEQ_WEIGHT_MSB:`PWEQ_WEIGHT_LSB];
      end
    end
  end

  // ==========================================
  // packet event counters; an event in the flush cycle counts from zero
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      for (i = 0; i < NQ; i = i + 1)
        evCnt_r[i] <= 24'h0;
    end
    else
    begin
      for (i = 0; i < NQ; i = i + 1)
      begin
        if (flushHit)
          evCnt_r[i] <= {23'h0, pktEvent[i]};
        else if (pktEvent[i])
          evCnt_r[i] <= evCnt_r[i] + 24'h1;
      end
    end
  end

  // ==========================================
  // drop decision, answered one clock after chkValid
  wire [10:0] cAvg  = qAvgSize[11*chkQueue +: 11];
  wire [10:0] cMax  = qMax_r[chkQueue];
  wire [10:0] cMin  = qMin_r[chkQueue];
  wire [10:0] cDiff = cAvg - cMin;
  wire [21:0] cProd = cDiff * qMult_r[chkQueue];
  wire [10:0] pDiff = pmAvgSize - pmMin_r;
  wire [21:0] pProd = pDiff * pmMult_r;
  // probability scaled down; anything beyond 11 bits saturates to always
  wire [21:0] cScl  = cProd >> `PWEQ_PROB_SHIFT;
  wire [21:0] pScl  = pProd >> `PWEQ_PROB_SHIFT;
  wire        cProb = (|cScl[21:11]) | (chkRand < cScl[10:0]);
  wire        pProb = (|pScl[21:11]) | (chkRand < pScl[10:0]);

  reg colorOff;
  reg qDrop;
  reg pmDrop;
  always @*
  begin
    colorOff = allColorOff_r;
    if (chkColor == `PWEQ_COLOR_YELLOW || chkColor == `PWEQ_COLOR_RED)
      colorOff = colorOff | upperColorOff_r;
    if (chkColor == `PWEQ_COLOR_RED)
      colorOff = colorOff | redOff_r;
    qDrop = 1'b0;
    if (cAvg > cMax)
      qDrop = dropAll_r | cProb;
    else if (cAvg > cMin)
      qDrop = cProb;
    pmDrop = 1'b0;
    if (pmAvgSize > pmMax_r)
      pmDrop = 1'b1;
    else if (pmAvgSize > pmMin_r)
      pmDrop = pProb;
  end

  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      dropValid_r <= 1'b0;
      dropPkt_r   <= 1'b0;
    end
    else
    begin
      dropValid_r <= chkValid;
      dropPkt_r   <= chkValid & policeEn_r & randDropEn_r & ~colorOff
                     & (qDrop | pmDrop);
    end
  end

  // ==========================================
  // egress scheduler; port-wide mode follows queue 0's setting
  reg  [3:0] actMask;
  always @*
  begin
    if (txNumQueues == `PWEQ_NUMQ_ONE)
      actMask = `PWEQ_MASK_ONE;
    else if (txNumQueues == `PWEQ_NUMQ_TWO)
      actMask = `PWEQ_MASK_TWO;
    else
      actMask = `PWEQ_MASK_FOUR;
  end

  // queues NQ and above never become eligible
  reg  [3:0] elig;
  integer    e;
  always @*
  begin
    elig = 4'h0;
    for (e = 0; e < NQ; e = e + 1)
      elig[e] = qNotEmpty[e] & actMask[e];
  end
  wire       multiQ = (txNumQueues != `PWEQ_NUMQ_ONE);
  wire       strict = (sched_r[0] == `PWEQ_SCHED_STRICT);

  reg        pickOk;
  reg  [1:0] pickQ;
  reg        nextOk;
  reg  [1:0] nextQ;
  reg  [1:0] cand;
  integer    k;
  always @*
  begin
    pickOk = 1'b0;
    pickQ  = 2'h0;
    for (k = 0; k < 4; k = k + 1)
      if (elig[k])
      begin
        pickOk = 1'b1;
        pickQ  = k[1:0];
      end
    nextOk = 1'b0;
    nextQ  = curQ_r;
    cand   = curQ_r;
    for (k = 1; k < 5; k = k + 1)
    begin
      cand = curQ_r - k[1:0];
      if (!nextOk && elig[cand])
      begin
        nextOk = 1'b1;
        nextQ  = cand;
      end
    end
  end

  // reserved mode codes fall back to the rotation; a zero weight still
  // lets one packet through so the queue cannot starve the rotation
  wire stay = elig[curQ_r] & (sent_r < weight_r[curQ_r]);

  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      grantValid_r <= 1'b0;
      grantQueue_r <= 2'h0;
      curQ_r       <= 2'h0;
      sent_r       <= 7'h0;
    end
    else if (txPick)
    begin
      if (!multiQ)
      begin
        grantValid_r <= elig[0];
        grantQueue_r <= 2'h0;
      end
      else if (strict)
      begin
        grantValid_r <= pickOk;
        grantQueue_r <= pickQ;
      end
      else if (stay)
      begin
        grantValid_r <= 1'b1;
        grantQueue_r <= curQ_r;
        sent_r       <= sent_r + 7'h1;
      end
      else
      begin
        grantValid_r <= nextOk;
        grantQueue_r <= nextQ;
        curQ_r       <= nextQ;
        sent_r       <= {6'h0, nextOk};
      end
    end
    else
      grantValid_r <= 1'b0;
  end

  // ==========================================
  // outputs
  genvar g;
  generate
    for (g = 0; g < NQ; g = g + 1)
    begin : gShaper
      assign shaperMode[2*g +: 2] = shaper_r[g];
    end
  endgenerate

  assign prdata     = prdata_r;
  assign pready     = pready_r;
  assign pslverr    = pslverr_r;
  assign dropValid  = dropValid_r;
  assign dropPkt    = dropPkt_r;
  assign grantValid = grantValid_r;
  assign grantQueue = grantQueue_r;
  assign vidSwapEn  = vidSwap_r;

endmodule // pweq_port_ctrl
`default_nettype wire

// file: verif/pweq_port_ctrl_properties.sv
// concurrent checks on the port pins of the drop and egress control bank
// assumes one clock domain and a synchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// checker
module pweq_port_ctrl_checker
#(
  parameter NQ = 4
)
(
  input wire logic            clock,
  input wire logic            rst_n,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [31:0]     prdata,
  input wire logic            pready,
  input wire logic            pslverr,
  input wire logic            chkValid,
  input wire logic            dropValid,
  input wire logic            dropPkt,
  input wire logic [1:0]      txNumQueues,
  input wire logic [NQ-1:0]   qNotEmpty,
  input wire logic            txPick,
  input wire logic            grantValid,
  input wire logic [1:0]      grantQueue,
  input wire logic [2*NQ-1:0] shaperMode,
  input wire logic            vidSwapEn
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  property p_ready_wait;
    psel && penable && !pready |=> pready;
  endproperty
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  property p_rdata_idle;
    !pready |-> prdata == 32'h0;
  endproperty
  property p_drop_answer;
    chkValid |=> dropValid;
  endproperty
  property p_drop_cause;
    dropValid |-> $past(chkValid);
  endproperty
  property p_drop_qual;
    dropPkt |-> dropValid;
  endproperty
  property p_grant_cause;
    grantValid |-> $past(txPick);
  endproperty
  property p_grant_elig;
    grantValid |-> (($past(qNotEmpty) >> grantQueue) & 1) != 0;
  endproperty
  property p_one_queue;
    txPick && txNumQueues == 2'h0 |=> !grantValid || grantQueue == 2'h0;
  endproperty
  property p_cfg_by_write;
    !$stable(shaperMode) || !$stable(vidSwapEn) |-> $past(pready && pwrite);
  endproperty
  a_ready_wait: assert property (p_ready_wait)
    else $error("access not answered after one wait state");
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready held longer than one cycle");
  a_err_ready: assert property (p_err_ready)
    else $error("error flag without ready");
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside answer");
  a_drop_answer: assert property (p_drop_answer)
    else $error("drop check not answered next cycle");
  a_drop_cause: assert property (p_drop_cause)
    else $error("drop answer without check");
  a_drop_qual: assert property (p_drop_qual)
    else $error("drop decision without valid");
  a_grant_cause: assert property (p_grant_cause)
    else $error("grant without pick");
  a_grant_elig: assert property (p_grant_elig)
    else $error("grant to empty queue");
  a_one_queue: assert property (p_one_queue)
    else $error("single queue mode granted other queue");
  a_cfg_by_write: assert property (p_cfg_by_write)
    else $error("mode outputs changed without a write");
  c_write: cover property (pready && pwrite);
  c_drop: cover property (dropValid && dropPkt);
  c_grant: cover property (grantValid && grantQueue == 2'h3);
endmodule // pweq_port_ctrl_checker

bind pweq_port_ctrl pweq_port_ctrl_checker #(.NQ(NQ)) u_chk
(
  .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .chkValid(chkValid), .dropValid(dropValid), .dropPkt(dropPkt),
  .txNumQueues(txNumQueues), .qNotEmpty(qNotEmpty), .txPick(txPick),
  .grantValid(grantValid), .grantQueue(grantQueue),
  .shaperMode(shaperMode), .vidSwapEn(vidSwapEn)
);
`default_nettype wire

// file: verif/pweq_tb_top.sv
// self-checking bench for the drop and egress control bank
// assumes the bench acts as apb master and as the switch datapath
`timescale 1ns/100ps
`default_nettype none
`include "pweq_port_ctrl_regs.vh"
module tb_top;
  logic        clock, rst_n, psel, penable, pwrite, pready, pslverr, err;
  logic        chkValid, dropValid, dropPkt, txPick, grantValid, vidSwapEn;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, ex;
  logic [3:0]  pstrb, pktEvent, qNotEmpty;
  logic [10:0] pmAvgSize, chkRand;
  logic [43:0] qAvgSize;
  logic [1:0]  chkQueue, chkColor, txNumQueues, grantQueue, prev;
  logic [7:0]  shaperMode;
  integer      badCount, testsRun, cycles, i, run;
  pweq_port_ctrl uut
  (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pmAvgSize(pmAvgSize), .qAvgSize(qAvgSize), .pktEvent(pktEvent),
    .chkValid(chkValid), .chkQueue(chkQueue), .chkColor(chkColor),
    .chkRand(chkRand), .dropValid(dropValid), .dropPkt(dropPkt),
    .txNumQueues(txNumQueues), .qNotEmpty(qNotEmpty), .txPick(txPick),
    .grantValid(grantValid), .grantQueue(grantQueue),
    .shaperMode(shaperMode), .vidSwapEn(vidSwapEn)
  );
  // ==========================================
  // shared tasks
  task printVerdict;
    begin
      if (badCount == 0 && testsRun > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      testsRun = testsRun + 1;
      if (got !== exp)
      begin
        badCount = badCount + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // request held until ready is seen high at a rising edge
  task apb(input [11:0] a, input [31:0] d, input [3:0] s, input w);
    integer n;
    begin
      @(posedge clock);
      psel    <= 1'b1;
      paddr   <= a;
      pwdata  <= d;
      pstrb   <= s;
      pwrite  <= w;
      @(posedge clock);
      penable <= 1'b1;
      n = 0;
      do
      begin
        @(posedge clock);
        n = n + 1;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1)
        badCount = badCount + 1;
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    apb(a, d, 4'hf, 1'b1);
  endtask
  task rdx(input [11:0] a, input [31:0] exp);
    begin
      apb(a, 32'h0, 4'h0, 1'b0);
      cmp(rd, exp);
    end
  endtask
  task pick;
    begin
      @(posedge clock);
      txPick <= 1'b1;
      @(posedge clock);
      txPick <= 1'b0;
      @(posedge clock);
    end
  endtask
  task drop(input [31:0] c, input [1:0] col, input [10:0] r, input e);
    begin
      wr(`PWEQ_ADDR_Q_MON_CTRL, c);
      @(posedge clock);
      chkValid <= 1'b1;
      chkColor <= col;
      chkRand  <= r;
      @(posedge clock);
      chkValid <= 1'b0;
      @(posedge clock);
      cmp({dropValid, dropPkt}, {1'b1, e});
    end
  endtask
  // ==========================================
  // scenarios
  task t_reset;
    begin
      rdx(`PWEQ_ADDR_POLICE_CTRL, 32'h0);
      rdx(`PWEQ_ADDR_PM_THRESHOLDS, 32'h0400_0080);
      rdx(`PWEQ_ADDR_PM_MULT_AVG, 32'h0020_0155);
      rdx(`PWEQ_ADDR_Q_THRESHOLDS, 32'h0080_0009);
      rdx(`PWEQ_ADDR_Q_MULT_AVG, 32'h0010_0011);
      rdx(`PWEQ_ADDR_Q_MON_CTRL, 32'h0);
      rdx(`PWEQ_ADDR_Q_SELECT, 32'h0);
      rdx(`PWEQ_ADDR_VID_SWAP, 32'h0);
      rdx(`PWEQ_ADDR_SCHED_SHAPER, 32'h0000_0180);
    end
  endtask
  task t_reserved;
    begin
      wr(`PWEQ_ADDR_PM_THRESHOLDS, 32'hffff_ffff);
      rdx(`PWEQ_ADDR_PM_THRESHOLDS, 32'h07ff_07ff);
      wr(`PWEQ_ADDR_PM_MULT_AVG, 32'hffff_ffff);
      rdx(`PWEQ_ADDR_PM_MULT_AVG, 32'h07ff_0155);
      wr(`PWEQ_ADDR_VID_SWAP, 32'hffff_ffff);
      rdx(`PWEQ_ADDR_VID_SWAP, 32'h1);
      cmp(vidSwapEn, 1'b1);
      wr(12'h9fc, 32'hffff_ffff);
      cmp(err, 1'b1);
      rdx(12'h9fc, 32'h0);
    end
  endtask
  // odd queues are selected through the single byte lane
  task t_indexed;
    begin
      for (i = 0; i < 4; i = i + 1)
      begin
        if (i % 2)
          apb(`PWEQ_ADDR_Q_SELECT, i << 24, `PWEQ_STRB_BYTE3_ONLY, 1'b1);
        else
          wr(`PWEQ_ADDR_Q_SELECT, i);
        rdx(`PWEQ_ADDR_Q_SELECT, (i << 24) | i);
        wr(`PWEQ_ADDR_Q_THRESHOLDS, 32'hffff_fff0 + i);
        wr(`PWEQ_ADDR_SCHED_SHAPER,
           32'hffff_808f | ((i % 3) << 4) | ((i + 1) << 8));
      end
      for (i = 0; i < 4; i = i + 1)
      begin
        wr(`PWEQ_ADDR_Q_SELECT, i);
        rdx(`PWEQ_ADDR_Q_THRESHOLDS, 32'h07ff_07f0 + i);
        rdx(`PWEQ_ADDR_Q_MULT_AVG, 32'h0010_0000 | qAvgSize[11*i +: 11]);
        rdx(`PWEQ_ADDR_SCHED_SHAPER, 32'h80 | ((i % 3) << 4) | ((i + 1) << 8));
      end
      cmp(shaperMode, 8'h24);
    end
  endtask
  task t_counter;
    begin
      wr(`PWEQ_ADDR_Q_SELECT, 32'h2);
      @(posedge clock);
      pktEvent <= 4'h4;
      repeat (5) @(posedge clock);
      pktEvent <= 4'h0;
      rdx(`PWEQ_ADDR_Q_MON_CTRL, 32'h5);
      wr(`PWEQ_ADDR_Q_MON_CTRL, 32'h4000_0000);
      rdx(`PWEQ_ADDR_Q_MON_CTRL, 32'h4000_0000);
      @(posedge clock);
      pktEvent <= 4'h4;
      repeat (3) @(posedge clock);
      pktEvent <= 4'h0;
      wr(`PWEQ_ADDR_Q_MON_CTRL, 32'h4000_0000);
      rdx(`PWEQ_ADDR_Q_MON_CTRL, 32'h4000_0003);
      wr(`PWEQ_ADDR_Q_MON_CTRL, 32'h0);
      rdx(`PWEQ_ADDR_Q_MON_CTRL, 32'h3);
    end
  endtask
  // queue 1 average sits above its max, packet memory stays below its min
  task t_drop;
    begin
      wr(`PWEQ_ADDR_POLICE_CTRL, 32'h1);
      wr(`PWEQ_ADDR_Q_SELECT, 32'h1);
      wr(`PWEQ_ADDR_Q_THRESHOLDS, 32'h0020_0010);
      wr(`PWEQ_ADDR_Q_MULT_AVG, 32'h0);
      drop(32'h8400_0000, `PWEQ_COLOR_RED, 11'h0, 1'b1);
      drop(32'h8c00_0000, `PWEQ_COLOR_RED, 11'h0, 1'b0);
      drop(32'h8c00_0000, `PWEQ_COLOR_YELLOW, 11'h0, 1'b1);
      drop(32'h9400_0000, `PWEQ_COLOR_YELLOW, 11'h0, 1'b0);
      drop(32'h9400_0000, `PWEQ_COLOR_GREEN, 11'h0, 1'b1);
      drop(32'ha400_0000, `PWEQ_COLOR_GREEN, 11'h0, 1'b0);
      drop(32'h0400_0000, `PWEQ_COLOR_GREEN, 11'h0, 1'b0);
      drop(32'h8000_0000, `PWEQ_COLOR_GREEN, 11'h0, 1'b0);
      wr(`PWEQ_ADDR_Q_MULT_AVG, 32'h07ff_0000);
      drop(32'h8000_0000, `PWEQ_COLOR_GREEN, 11'h0, 1'b1);
      drop(32'h8000_0000, `PWEQ_COLOR_GREEN, 11'h7ff, 1'b0);
      wr(`PWEQ_ADDR_POLICE_CTRL, 32'h0);
      drop(32'h8400_0000, `PWEQ_COLOR_RED, 11'h0, 1'b0);
    end
  endtask
  task t_sched;
    begin
      wr(`PWEQ_ADDR_Q_SELECT, 32'h0);
      wr(`PWEQ_ADDR_SCHED_SHAPER, 32'h0000_0100);
      qNotEmpty <= 4'b1010;
      pick;
      cmp({grantValid, grantQueue}, 3'b111);
      qNotEmpty <= 4'b0011;
      pick;
      cmp({grantValid, grantQueue}, 3'b101);
      txNumQueues <= `PWEQ_NUMQ_TWO;
      qNotEmpty <= 4'b1100;
      pick;
      cmp(grantValid, 1'b0);
      txNumQueues <= `PWEQ_NUMQ_ONE;
      qNotEmpty <= 4'b1111;
      pick;
      cmp({grantValid, grantQueue}, 3'b100);
      txNumQueues <= 2'h2;
      wr(`PWEQ_ADDR_SCHED_SHAPER, 32'h0000_0180);
      run = -1;
      // weights are queue number plus one; first run may start part way
      for (i = 0; i < 24; i = i + 1)
      begin
        pick;
        if (i > 0 && grantQueue !== prev)
        begin
          if (run > 0)
            cmp(run, prev + 1);
          cmp({30'h0, grantQueue}, {30'h0, prev - 2'h1});
          run = (run < 0) ? 0 : run;
          run = 0;
        end
        run = (i == 0) ? -1 : ((run < 0) ? -1 : run + 1);
        prev = grantQueue;
      end
    end
  endtask
  // ==========================================
  // clock, reset, timeout and main sequence
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  initial
  begin
    {rst_n, psel, penable, pwrite, chkValid, txPick} = 6'h0;
    {paddr, pwdata, pstrb, pktEvent, chkRand} = 63'h0;
    {chkQueue, chkColor, txNumQueues} = {2'h1, 2'h0, 2'h2};
    pmAvgSize = 11'h155;
    qAvgSize = {11'h033, 11'h022, 11'h030, 11'h011};
    qNotEmpty = 4'h0;
    prev = 2'h0;
    {badCount, testsRun, cycles} = 96'h0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    t_reset;
    t_reserved;
    t_indexed;
    t_counter;
    t_drop;
    t_sched;
    printVerdict;
  end
  always @(posedge clock)
  begin
    cycles = cycles + 1;
    if (cycles == 8000)
    begin
      badCount = badCount + 1;
      printVerdict;
    end
  end
endmodule // tb_top
`default_nettype wire
